/* design/ccsr_pkg.sv */
// What this block does
// - done current threshold, bits 7-4, reset 0001
// - voltage target, bits 3-0, reset 1010
// - fast charge moves to cv at target
// - bits 7-6 pick overvoltage threshold
// - bit 5 stops charging after 30 minutes in cv
// - bit 4 picks fixed 90 mA or field
// - bits 3-0 fast current, reset 0101
// - six event flags, clear on read
// - mask bits, 1 masks, reset 0
// - fast timer expiry sets bit 7, disables
// - precharge timer expiry sets bit 6, disables
// - status bit 5 shows other faults
// - status bits 4-0 show live state
// - enable override reset 1, starts charging without a charger unless faulted or locked out
// - fast timer 5/6/7 hours or off
package ccsr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL1 = 8'h20; // override and fast timer
  localparam logic [7:0] ADDR_TERM_VOLT = 8'h21;
  localparam logic [7:0] ADDR_PROT_CURR = 8'h22;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h24;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h25;
  localparam logic [7:0] ADDR_STATE_REPORT = 8'h26;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CTRL1 = 8'h10; // override set, 5 h timer
  localparam logic [7:0] RST_TERM_VOLT = 8'h1a;
  localparam logic [7:0] RST_PROT_CURR = 8'h05;
  localparam logic [5:0] RST_EVENT_MASK = 6'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int OVERRIDE_BIT = 4;
  localparam int AUTO_CHARGE_SHUTOFF_BIT = 5;
  localparam int RANGE_SEL_BIT = 4;
  localparam int FAST_TIMER_EXP_BIT = 7;
  localparam int PRE_TIMER_EXP_BIT = 6;
  localparam int FAULT_BIT = 5;
  localparam int DONE_BIT = 4;
  localparam int CV_BIT = 3;
  localparam int FAST_BIT = 2;
  localparam int PRE_BIT = 1;
  localparam int IDLE_BIT = 0;
  localparam logic [1:0] FAST_TIMER_OFF = 2'h3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_S = 1; // timers count whole seconds
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int MINUTE_S = 60;
  localparam int HOUR_S = 3600;
  localparam logic [14:0] PRE_LIMIT_S = 15'(30 * MINUTE_S);
  localparam logic [14:0] STOP_LIMIT_S = 15'(30 * MINUTE_S);
  localparam logic [14:0] FAST_5H_S = 15'(5 * HOUR_S);
  localparam logic [14:0] FAST_6H_S = 15'(6 * HOUR_S);
  localparam logic [14:0] FAST_7H_S = 15'(7 * HOUR_S);

  // ----------------------------------------
  // charger states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_FAST, ST_CV, ST_DONE, ST_FAULT
  } ccsr_state_t;
endpackage : ccsr_pkg

/* design/ccsr_regs.sv */
module ccsr_regs #(
  parameter int TICK_CYCLES = ccsr_pkg::TICK_CYCLES // shorten in sim
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic charger_detected_in,
  input wire logic batt_above_pre_in,
  input wire logic [3:0] batt_voltage_code_in,
  input wire logic fault_in,
  output logic charge_enable_out,
  output logic [3:0] done_current_threshold_out,
  output logic [3:0] constant_voltage_target_out,
  output logic [1:0] overvoltage_threshold_out,
  output logic fast_current_fixed_out,
  output logic [3:0] fast_charge_current_out,
  output logic irq_out
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] ctrl1; // override and fast timer only
  logic [7:0] term_volt; // threshold and cv target
  logic [7:0] prot_curr; // ovp, auto_charge_shutoff, current
  logic [5:0] event_flags; // sticky, clear on read
  logic [5:0] event_mask; // 1 masks
  logic fast_timer_expired; // lockout latch
  logic precharge_timer_expired; // lockout latch
  ccsr_pkg::ccsr_state_t state;
  ccsr_pkg::ccsr_state_t next_state;
  logic detect_prev; // for re-attach edge
  logic [25:0] tick_count; // cycles within a second
  logic [14:0] sec_count; // seconds in present state

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // strobes need the clock enable, so a frozen block drops host access
  wire wr_en = ce_in & reg_wr_in;
  wire rd_en = ce_in & reg_rd_in;
  wire wr_ctrl1 = wr_en & (reg_addr_in == ccsr_pkg::ADDR_CTRL1);
  wire wr_term = wr_en & (reg_addr_in == ccsr_pkg::ADDR_TERM_VOLT);
  wire wr_prot = wr_en & (reg_addr_in == ccsr_pkg::ADDR_PROT_CURR);
  wire wr_mask = wr_en & (reg_addr_in == ccsr_pkg::ADDR_EVENT_MASK);
  wire rd_flags = rd_en & (reg_addr_in == ccsr_pkg::ADDR_EVENT_FLAGS);
  wire override_bit = ctrl1[ccsr_pkg::OVERRIDE_BIT];
  // a write that flips the override counts as a toggle
  wire override_toggle = wr_ctrl1 &
    (reg_wdata_in[ccsr_pkg::OVERRIDE_BIT] != override_bit);
  wire reattach = charger_detected_in & ~detect_prev;
  wire lockout_clear = override_toggle | reattach;
  wire enabled = override_bit | charger_detected_in;
  wire locked = fast_timer_expired | precharge_timer_expired;
  wire run_ok = enabled & ~locked;
  wire second_tick = (tick_count == 26'(TICK_CYCLES - 1));
  wire auto_charge_shutoff = prot_curr[ccsr_pkg::AUTO_CHARGE_SHUTOFF_BIT];
  wire [1:0] fast_time_code = ctrl1[1:0];
  wire at_cv_target = batt_voltage_code_in >= term_volt[3:0];

  // fast timer limit from the two-bit time field
  wire [14:0] fast_limit =
    (fast_time_code == 2'h0) ? ccsr_pkg::FAST_5H_S :
    (fast_time_code == 2'h1) ? ccsr_pkg::FAST_6H_S :
    ccsr_pkg::FAST_7H_S;
  wire fast_expire = (state == ccsr_pkg::ST_FAST) & second_tick &
    (fast_time_code != ccsr_pkg::FAST_TIMER_OFF) &
    (sec_count == fast_limit - 15'h1);
  wire pre_expire = (state == ccsr_pkg::ST_PRE) & second_tick &
    (sec_count == ccsr_pkg::PRE_LIMIT_S - 15'h1);
  wire stop_expire = (state == ccsr_pkg::ST_CV) & auto_charge_shutoff &
    second_tick & (sec_count == ccsr_pkg::STOP_LIMIT_S - 15'h1);

  // one-hot live state, bit order matches the flags
  wire [5:0] state_bits = {
    state == ccsr_pkg::ST_FAULT, state == ccsr_pkg::ST_DONE,
    state == ccsr_pkg::ST_CV, state == ccsr_pkg::ST_FAST,
    state == ccsr_pkg::ST_PRE, state == ccsr_pkg::ST_IDLE};
  wire state_change = ce_in & (next_state != state);
  wire [5:0] entry_bits = {
    next_state == ccsr_pkg::ST_FAULT, next_state == ccsr_pkg::ST_DONE,
    next_state == ccsr_pkg::ST_CV, next_state == ccsr_pkg::ST_FAST,
    next_state == ccsr_pkg::ST_PRE, next_state == ccsr_pkg::ST_IDLE};
  wire [5:0] event_set = state_change ? entry_bits : 6'h00;
  // set wins over the clear of a read in the same cycle
  wire [5:0] next_flags =
    (event_flags & ~(rd_flags ? 6'h3f : 6'h00)) | event_set;
  wire [7:0] state_report = {fast_timer_expired,
    precharge_timer_expired, state_bits};

  // read mux, unmapped offsets read zero
  wire [7:0] read_value =
    (reg_addr_in == ccsr_pkg::ADDR_CTRL1) ?
      {3'h0, override_bit, 2'h0, fast_time_code} :
    (reg_addr_in == ccsr_pkg::ADDR_TERM_VOLT) ? term_volt :
    (reg_addr_in == ccsr_pkg::ADDR_PROT_CURR) ? prot_curr :
    (reg_addr_in == ccsr_pkg::ADDR_EVENT_FLAGS) ?
      {2'h0, event_flags} :
    (reg_addr_in == ccsr_pkg::ADDR_EVENT_MASK) ? {2'h0, event_mask} :
    (reg_addr_in == ccsr_pkg::ADDR_STATE_REPORT) ? state_report :
    8'h00;

  // ----------------------------------------
  // charger state machine
  // ----------------------------------------
  // fault and loss of enable take priority over progress
  always_comb begin
    next_state = state;
    case (state)
      ccsr_pkg::ST_IDLE: begin
        if (run_ok & ~fault_in) next_state = ccsr_pkg::ST_PRE;
      end
      ccsr_pkg::ST_PRE: begin
        if (pre_expire) next_state = ccsr_pkg::ST_IDLE;
        else if (batt_above_pre_in) next_state = ccsr_pkg::ST_FAST;
      end
      ccsr_pkg::ST_FAST: begin
        if (fast_expire) next_state = ccsr_pkg::ST_IDLE;
        else if (at_cv_target) next_state = ccsr_pkg::ST_CV;
      end
      ccsr_pkg::ST_CV: begin
        // without auto_charge_shutoff the charger holds cv until a fault or loss of enable
        if (stop_expire) next_state = ccsr_pkg::ST_DONE;
      end
      ccsr_pkg::ST_DONE: begin
        next_state = ccsr_pkg::ST_DONE;
      end
      ccsr_pkg::ST_FAULT: begin
        if (~fault_in) next_state = ccsr_pkg::ST_IDLE;
      end
      default: begin
        next_state = ccsr_pkg::ST_IDLE;
      end
    endcase
    if (state != ccsr_pkg::ST_IDLE && state != ccsr_pkg::ST_FAULT) begin
      if (fault_in) next_state = ccsr_pkg::ST_FAULT;
      else if (~enabled) next_state = ccsr_pkg::ST_IDLE;
    end
  end

  // state and edge memory
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= ccsr_pkg::ST_IDLE;
      detect_prev <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      detect_prev <= charger_detected_in;
    end
  end

  // ----------------------------------------
  // second prescaler and state timer
  // ----------------------------------------
  // timer restarts on each state change
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tick_count <= 26'h0;
      sec_count <= 15'h0;
    end else if (ce_in) begin
      if (next_state != state) begin
        tick_count <= 26'h0;
        sec_count <= 15'h0;
      end else if (second_tick) begin
        tick_count <= 26'h0;
        sec_count <= sec_count + 15'h1;
      end else begin
        tick_count <= tick_count + 26'h1;
      end
    end
  end

  // ----------------------------------------
  // timer lockout latches
  // ----------------------------------------
  // expiry wins over a clear landing in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fast_timer_expired <= 1'b0;
      precharge_timer_expired <= 1'b0;
    end else if (ce_in) begin
      fast_timer_expired <= fast_expire |
        (fast_timer_expired & ~lockout_clear);
      precharge_timer_expired <= pre_expire |
        (precharge_timer_expired & ~lockout_clear);
    end
  end

  // ----------------------------------------
  // host registers
  // ----------------------------------------
  // configuration writes, status writes are ignored
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl1 <= ccsr_pkg::RST_CTRL1;
      term_volt <= ccsr_pkg::RST_TERM_VOLT;
      prot_curr <= ccsr_pkg::RST_PROT_CURR;
      event_mask <= ccsr_pkg::RST_EVENT_MASK;
    end else begin
      if (wr_ctrl1) ctrl1 <= {3'h0, reg_wdata_in[4], 2'h0,
        reg_wdata_in[1:0]};
      if (wr_term) term_volt <= reg_wdata_in;
      if (wr_prot) prot_curr <= reg_wdata_in;
      if (wr_mask) event_mask <= reg_wdata_in[5:0];
    end
  end

  // flags and read data
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      event_flags <= 6'h00;
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      event_flags <= next_flags;
      if (rd_en) reg_rdata_out <= read_value;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign charge_enable_out = (state == ccsr_pkg::ST_PRE) |
    (state == ccsr_pkg::ST_FAST) | (state == ccsr_pkg::ST_CV);
  assign done_current_threshold_out = term_volt[7:4];
  assign constant_voltage_target_out = term_volt[3:0];
  assign overvoltage_threshold_out = prot_curr[7:6];
  assign fast_current_fixed_out =
    ~prot_curr[ccsr_pkg::RANGE_SEL_BIT];
  assign fast_charge_current_out = prot_curr[3:0];
  assign irq_out = |(event_flags & ~event_mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence fast_at_target_s;
    ce_in && state == ccsr_pkg::ST_FAST && at_cv_target && !fault_in
      && enabled && !fast_expire;
  endsequence
  sequence flag_read_s;
    rd_flags && !event_set[0] && !event_set[1];
  endsequence

  // progress out of fast charge once the target is met
  fast_to_cv_a: assert property (
    fast_at_target_s |=> state == ccsr_pkg::ST_CV)
    else $error("fast charge did not move to cv");
  // a read empties the idle and precharge flags when no entry sets them again
  read_clear_a: assert property (
    flag_read_s |=> event_flags[1:0] == 2'h0)
    else $error("flag not cleared by read");
  // entry into fast charge is never lost to a read
  set_wins_a: assert property (
    event_set[2] |=> event_flags[2])
    else $error("state entry flag lost");
  // an unmasked entry must raise the interrupt line
  irq_mask_a: assert property (
    ce_in && (event_set & ~event_mask) != 6'h00 && !wr_mask |=>
      irq_out)
    else $error("unmasked event did not raise interrupt");
  // expiry drops charge enable at once
  fast_lock_a: assert property (
    fast_expire && ce_in |=> fast_timer_expired && !charge_enable_out)
    else $error("fast timer expiry did not lock out");
  // precharge expiry parks the charger in idle
  pre_lock_a: assert property (
    pre_expire && ce_in |=> precharge_timer_expired
      && state == ccsr_pkg::ST_IDLE)
    else $error("precharge timer expiry did not lock out");
  // only a re-attach or an override toggle lifts the lock
  lock_holds_a: assert property (
    locked && !lockout_clear && ce_in |=> locked)
    else $error("lockout dropped without restart");
  // without auto_charge_shutoff, cv holds while enabled and fault free
  no_auto_charge_shutoff_a: assert property (
    ce_in && state == ccsr_pkg::ST_CV && !auto_charge_shutoff && !fault_in
      && enabled |=> state == ccsr_pkg::ST_CV)
    else $error("cv ended with auto_charge_shutoff off");
  // a fault while charging shows in the status byte
  fault_flag_a: assert property (
    ce_in && fault_in && charge_enable_out |=> state_report[5])
    else $error("fault not reported");
  // timer code off keeps fast charge going below target
  timer_off_a: assert property (
    ce_in && state == ccsr_pkg::ST_FAST && !at_cv_target && !fault_in
      && enabled && fast_time_code == ccsr_pkg::FAST_TIMER_OFF |=>
      state == ccsr_pkg::ST_FAST)
    else $error("disabled fast timer expired");
  // the written range bit reaches the fixed-current output
  range_sel_a: assert property (
    wr_prot |=> fast_current_fixed_out ==
      !$past(reg_wdata_in[ccsr_pkg::RANGE_SEL_BIT]))
    else $error("range select not applied");
  // override alone starts a charge from idle
  override_run_a: assert property (
    ce_in && state == ccsr_pkg::ST_IDLE && override_bit && !locked
      && !fault_in |=> state == ccsr_pkg::ST_PRE)
    else $error("override did not start charging");
endmodule : ccsr_regs

/* verif/ccsr_host.sv */
// host side of the register port: one byte per request
module ccsr_host (
  input wire logic clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // write: held one edge, then lines scrambled so stale data never helps
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= v;
    reg_wr_out <= 1'b1;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~v;
  endtask : wr
  // read: data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    #1;
    v = reg_rdata_in;
  endtask : rd
endmodule : ccsr_host

/* verif/charger_config_status_regs_tb_top.sv */
module charger_config_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic clk_in, reset_in, ce_in, det, above, fault, wr, rd, en, fixed, irq;
  logic [7:0] addr, wdata, rdata, d;
  logic [3:0] vcode, thr, tgt, cur;
  logic [1:0] overvoltage_threshold;
  logic [31:0] seed = 32'h44276399; // fixed start
  int mismatches, tests_run, cyc, flg, msk;
  int regm [int]; // expected config bytes by offset
  ccsr_regs #(.TICK_CYCLES(2)) dut_u (.clk_in(clk_in), .reset_in(reset_in),
    .ce_in(ce_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .charger_detected_in(det), .batt_above_pre_in(above),
    .batt_voltage_code_in(vcode), .fault_in(fault),
    .charge_enable_out(en), .done_current_threshold_out(thr),
    .constant_voltage_target_out(tgt), .overvoltage_threshold_out(overvoltage_threshold),
    .fast_current_fixed_out(fixed), .fast_charge_current_out(cur),
    .irq_out(irq));
  ccsr_host host_u (.clk_in(clk_in), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
    .reg_rd_out(rd));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // hang guard: whole run is well under this
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      finish_test();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(d, e);
  endtask : rdc
  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    host_u.wr(a, v);
    regm[a] = v;
  endtask : wrr
  // field outputs against the model bytes
  task automatic ports();
    chk(8'(thr), 8'(regm[8'h21] >> 4));
    chk(8'(tgt), 8'(regm[8'h21] & 15));
    chk(8'(overvoltage_threshold), 8'(regm[8'h22] >> 6));
    chk(8'(fixed), 8'(~regm[8'h22] >> 4 & 1));
    chk(8'(cur), 8'(regm[8'h22] & 15));
  endtask : ports
  // charger inputs change on an edge, then the state settles
  task automatic go(input logic dt, ab, input logic [3:0] vc, input logic fl);
    @(posedge clk_in);
    det <= dt;
    above <= ab;
    vcode <= vc;
    fault <= fl;
    repeat (4) @(posedge clk_in);
  endtask : go
  // a state entered: status shows it alone, its flag latches
  task automatic seen(input int b);
    flg |= 1 << b;
    rdc(8'h26, 8'(1 << b));
    chk(8'(irq), 8'((flg & ~msk) != 0));
  endtask : seen
  // cycles that charge enable stays up, checked against a window
  task automatic hold(input int lo, input int hi);
    int n;
    n = 0;
    while (en === 1'b1 && n < hi + 20) begin
      @(posedge clk_in);
      #1; // look once the state register has settled
      n++;
    end
    tests_run++;
    if (n < lo || n > hi) begin
      $display("BAD t=%0t got=%h exp=%h", $time, n, lo + 8);
      mismatches++;
    end
  endtask : hold
  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_in = 1'b1;
    ce_in = 1'b0;
    {det, above, vcode} = '0;
    fault = 1'b1; // a fault holds idle until the override is off
    regm[8'h21] = 8'h1a;
    regm[8'h22] = 8'h05;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    host_u.wr(8'h21, 8'h00); // frozen: must not land
    ce_in <= 1'b1;
    rdc(8'h20, 8'h10);
    host_u.wr(8'h20, 8'h23); // override off, fast timer off
    rdc(8'h20, 8'h03);
    @(posedge clk_in);
    fault <= 1'b0;
    rdc(8'h21, 8'h1a);
    rdc(8'h22, 8'h05);
    rdc(8'h24, 8'h00);
    rdc(8'h25, 8'h00);
    rdc(8'h26, 8'h01);
    rdc(8'h30, 8'h00);
    ports();
    // random config and mask bytes, read back
    for (int i = 0; i < 8; i++) begin
      wrr(8'h21, xs());
      wrr(8'h22, xs());
      d = xs();
      host_u.wr(8'h25, d);
      msk = d & 63;
      rdc(8'h21, 8'(regm[8'h21]));
      rdc(8'h22, 8'(regm[8'h22]));
      rdc(8'h25, 8'(msk));
      ports();
    end
    // read-only places ignore writes
    host_u.wr(8'h26, 8'hff);
    host_u.wr(8'h24, 8'hff);
    rdc(8'h26, 8'h01);
    rdc(8'h24, 8'h00);
    wrr(8'h21, 8'h15);
    wrr(8'h22, 8'h05);
    msk = 0;
    host_u.wr(8'h25, 8'h00);
    // walk through the states with events unmasked
    go(1, 0, 0, 0);
    seen(1);
    rdc(8'h24, 8'(flg));
    flg = 0;
    rdc(8'h24, 8'h00);
    chk(8'(irq), 8'h00);
    go(1, 1, 4, 0);
    seen(2);
    go(1, 1, 5, 0);
    seen(3);
    go(1, 1, 5, 1);
    seen(5);
    go(0, 1, 5, 0);
    seen(0);
    rdc(8'h24, 8'(flg));
    flg = 0;
    // all masked, then auto stop out of cv
    msk = 63;
    host_u.wr(8'h25, 8'h3f);
    wrr(8'h22, 8'h25);
    go(1, 1, 0, 0);
    chk(8'(irq), 8'h00);
    rdc(8'h24, 8'h06);
    @(posedge clk_in);
    vcode <= 4'hf;
    hold(3600 - 8, 3600 + 8);
    rdc(8'h26, 8'h10);
    // fast timer expiry with lockout, then re-attach
    host_u.wr(8'h20, 8'h00); // fast timer back to 5 h
    go(0, 1, 0, 0);
    go(1, 1, 0, 0);
    hold(36000 - 8, 36000 + 8);
    rdc(8'h26, 8'h81);
    repeat (5) @(posedge clk_in);
    chk(8'(en), 8'h00);
    go(0, 0, 0, 0);
    go(1, 0, 0, 0);
    chk(8'(en), 8'h01);
    hold(3600 - 8, 3600 + 8);
    rdc(8'h26, 8'h41);
    // override toggle restarts with no charger seen
    go(0, 0, 0, 0);
    host_u.wr(8'h20, 8'h10);
    repeat (3) @(posedge clk_in);
    chk(8'(en), 8'h01);
    finish_test();
  end
endmodule : charger_config_status_regs_tb_top
